// ### rtl/htm_monitor.sv
/*
 * hard trip monitor: strap decode, config lock, threshold compare,
 * fault queue, trip flag, small status/interrupt register file.
 * assumes the strap is sampled by a pull-up/pull-down probe pair driven here,
 * the trip level arrives already digitised from the analog side, and
 * measurements are one-cycle valid pulses on CLK.
 */
`timescale 1ns/1ps

// Function
// - trip level code maps to a threshold held within 60 to 122 degrees.
// - strap sampled and decoded once after reset, selects channel and config.
// - strap decoder tells low, high and floating apart.
// - writes to the selected channel's configuration registers are blocked.
// - writes to the other channels' configuration stay allowed.
// - strap low gives channel 1 with transistor model and resistance correction.
// - strap floating gives channel 1 with both corrections off.
// - strap high gives channel 2 with auto-detected model and resistance correction.
// - trip flag sets after fault-queue consecutive readings above threshold.
// - trip flag clears once a reading falls below threshold.
// - trip flag goes only to shutdown logic, not to a pin.
// - every new reading of the selected channel is compared with threshold.
module htm_monitor
    import htm_pkg::*;
#(
    parameter int FAULT_QUEUE = `HTM_FAULT_QUEUE_DEF
) (
    // clock and reset
    input wire logic CLK,
    input wire logic RESET_N,
    // strap probe: pin level and weak pull drive
    input wire logic STRAP_IN,
    output logic STRAP_PULL_OUT,
    output logic STRAP_PULL_OE,
    // digitised trip level, 0 means minimum
    input wire logic [7:0] TRIP_LEVEL_INPUT,
    // measurements from the diode front end
    input wire htm_meas_t MEAS,
    // configuration write attempts from the serial bus side
    input wire logic CFG_WR,
    input wire logic [1:0] CFG_WR_CHAN,
    output logic CFG_WR_ALLOW,
    // config to the front end and trip to shutdown logic
    output htm_chan_cfg_t CHAN_CFG,
    output logic HARD_TRIP_FLAG,
    // register port
    input wire logic [3:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [7:0] REG_RDATA,
    output logic IRQ
);

    localparam int SETTLE = `HTM_STRAP_SETTLE_CYC;

    // ****************************************
    // strap probe sequence
    // ****************************************
    typedef enum logic [2:0] {S_PULL_UP, S_SAMPLE_UP, S_PULL_DN, S_SAMPLE_DN, S_DONE} htm_state_t;
    htm_state_t state_q, state_d;
    logic [7:0] settle_q;
    logic sync1_q, sync2_q;
    logic up_seen_q, dn_seen_q;
    htm_chan_cfg_t cfg_q, cfg_d;

    // two-flop synchroniser on the strap pin
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
        end else begin
            sync1_q <= STRAP_IN;
            sync2_q <= sync1_q;
        end
    end

    wire settle_done = (settle_q == 8'(SETTLE + 2));
    // pull the pin up, then down; a floating pin follows the pull
    assign STRAP_PULL_OE = (state_q != S_DONE);
    assign STRAP_PULL_OUT = (state_q == S_PULL_UP) || (state_q == S_SAMPLE_UP);

    // the pulled-down sample lands on the same edge that latches the config, so read it live
    wire dn_level = (state_q == S_SAMPLE_DN) ? sync2_q : dn_seen_q;
    wire htm_strap_t strap_code = (!up_seen_q) ? HTM_STRAP_LOW :
                                  (dn_level ? HTM_STRAP_HIGH : HTM_STRAP_OPEN);

    always_comb begin
        cfg_d = '0;
        cfg_d.locked = 1'b1;
        case (strap_code)
            HTM_STRAP_LOW: begin
                cfg_d.channel = 2'd1;
                cfg_d.transistor_model = 1'b1;
                cfg_d.series_resistance_correction = 1'b1;
            end
            HTM_STRAP_OPEN: begin
                cfg_d.channel = 2'd1;
            end
            HTM_STRAP_HIGH: begin
                cfg_d.channel = 2'd2;
                cfg_d.transistor_model = 1'b1;
                cfg_d.auto_detect = 1'b1;
                cfg_d.series_resistance_correction = 1'b1;
            end
            default: begin
                cfg_d.channel = 2'd1;
            end
        endcase
    end

    // probe sequencing
    always_comb begin
        state_d = state_q;
        case (state_q)
            S_PULL_UP: if (settle_done) state_d = S_SAMPLE_UP;
            S_SAMPLE_UP: state_d = S_PULL_DN;
            S_PULL_DN: if (settle_done) state_d = S_SAMPLE_DN;
            S_SAMPLE_DN: state_d = S_DONE;
            S_DONE: state_d = S_DONE;
            default: state_d = S_DONE;
        endcase
    end

    // sample once, then hold until reset
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            state_q <= S_PULL_UP;
            settle_q <= 8'h00;
            up_seen_q <= 1'b0;
            dn_seen_q <= 1'b0;
            cfg_q <= '0;
        end else begin
            state_q <= state_d;
            settle_q <= (state_d != state_q) ? 8'h00 : (settle_done ? settle_q : settle_q + 8'h01);
            if (state_q == S_SAMPLE_UP) up_seen_q <= sync2_q;
            if (state_q == S_SAMPLE_DN) dn_seen_q <= sync2_q;
            if (state_q == S_SAMPLE_DN) cfg_q <= cfg_d;
        end
    end
    wire decoded = (state_q == S_DONE);
    assign CHAN_CFG = cfg_q;

    // ****************************************
    // configuration write lock
    // ****************************************
    // only the selected channel is locked
    assign CFG_WR_ALLOW = !(cfg_q.locked && (CFG_WR_CHAN == cfg_q.channel));
    wire wr_blocked = CFG_WR && !CFG_WR_ALLOW;

    // ****************************************
    // threshold and fault queue
    // ****************************************
    // clamp to whole degrees in range
    wire [8:0] trip_sum = {1'b0, TRIP_LEVEL_INPUT} + {1'b0, `HTM_TRIP_MIN_C};
    wire [7:0] thresh = (trip_sum > {1'b0, `HTM_TRIP_MAX_C}) ? `HTM_TRIP_MAX_C : trip_sum[7:0];
    logic [7:0] thresh_q;
    logic [7:0] count_q;
    logic trip_q;

    // only the selected channel's fresh readings count
    wire meas_ok = decoded && MEAS.valid && (MEAS.channel == cfg_q.channel);
    wire over = MEAS.degrees > thresh_q;
    wire under = MEAS.degrees < thresh_q;
    wire [7:0] count_next = over ? ((count_q == 8'(FAULT_QUEUE)) ? count_q : count_q + 8'h01) : 8'h00;
    wire trip_level_input = meas_ok && over && (count_next == 8'(FAULT_QUEUE)) && !trip_q;
    wire trip_clr = meas_ok && under && trip_q;

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            thresh_q <= `HTM_TRIP_MAX_C;
            count_q <= 8'h00;
            trip_q <= 1'b0;
        end else begin
            thresh_q <= thresh;
            if (meas_ok) count_q <= count_next;
            if (trip_level_input) trip_q <= 1'b1;
            else if (trip_clr) trip_q <= 1'b0;
        end
    end
    // internal flag to shutdown logic only
    assign HARD_TRIP_FLAG = trip_q;

    // ****************************************
    // status, interrupt and register read
    // ****************************************
    logic [`HTM_ST_WIDTH-1:0] status_q, enable_q;
    wire [`HTM_ST_WIDTH-1:0] events = {wr_blocked, trip_clr, trip_level_input};
    wire [`HTM_ST_WIDTH-1:0] clr_bits =
        (REG_WR && REG_ADDR == `HTM_ADDR_CLEAR) ? REG_WDATA[`HTM_ST_WIDTH-1:0] : '0;
    wire [7:0] rd_mux =
        (REG_ADDR == `HTM_ADDR_STATUS) ? {5'h00, status_q} :
        (REG_ADDR == `HTM_ADDR_ENABLE) ? {5'h00, enable_q} :
        (REG_ADDR == `HTM_ADDR_CONFIG) ? {2'h0, cfg_q} :
        (REG_ADDR == `HTM_ADDR_THRESH) ? thresh_q : 8'h00;

    // set wins over clear
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            status_q <= '0;
            enable_q <= '0;
            REG_RDATA <= 8'h00;
        end else begin
            status_q <= (status_q & ~clr_bits) | events;
            if (REG_WR && REG_ADDR == `HTM_ADDR_ENABLE) enable_q <= REG_WDATA[`HTM_ST_WIDTH-1:0];
            REG_RDATA <= REG_RD ? rd_mux : 8'h00;
        end
    end
    assign IRQ = |(status_q & enable_q);

    // ****************************************
    // checks
    // ****************************************
    chk_lock_selected: assert property (@(posedge CLK) disable iff (!RESET_N)
        (decoded && CFG_WR_CHAN == cfg_q.channel) |-> !CFG_WR_ALLOW)
        else $error("selected channel write not blocked");
    chk_other_open: assert property (@(posedge CLK) disable iff (!RESET_N)
        (CFG_WR_CHAN != cfg_q.channel) |-> CFG_WR_ALLOW)
        else $error("other channel write blocked");
    chk_cfg_held: assert property (@(posedge CLK) disable iff (!RESET_N)
        decoded |=> $stable(cfg_q))
        else $error("strap config changed after decode");
    chk_open_mode: assert property (@(posedge CLK) disable iff (!RESET_N)
        (decoded && up_seen_q && !dn_seen_q) |-> (cfg_q.channel == 2'd1 && !cfg_q.transistor_model
         && !cfg_q.series_resistance_correction))
        else $error("floating strap config wrong");
    chk_high_mode: assert property (@(posedge CLK) disable iff (!RESET_N)
        (decoded && dn_seen_q) |-> (cfg_q.channel == 2'd2 && cfg_q.auto_detect))
        else $error("high strap config wrong");
    chk_low_mode: assert property (@(posedge CLK) disable iff (!RESET_N)
        (decoded && !up_seen_q) |-> (cfg_q.channel == 2'd1 && cfg_q.transistor_model
         && cfg_q.series_resistance_correction))
        else $error("low strap config wrong");
    chk_trip_needs_queue: assert property (@(posedge CLK) disable iff (!RESET_N)
        $rose(trip_q) |-> $past(count_next) == 8'(FAULT_QUEUE))
        else $error("trip_level_input before queue filled");
    chk_trip_clears: assert property (@(posedge CLK) disable iff (!RESET_N)
        (meas_ok && under && trip_q) |=> !trip_q)
        else $error("trip not cleared below threshold");
    chk_count_reset: assert property (@(posedge CLK) disable iff (!RESET_N)
        (meas_ok && !over) |=> count_q == 8'h00)
        else $error("queue count not cleared");
    chk_thresh_range: assert property (@(posedge CLK) disable iff (!RESET_N)
        thresh_q >= `HTM_TRIP_MIN_C && thresh_q <= `HTM_TRIP_MAX_C)
        else $error("threshold out of range");

    // probe drive and one-shot decode
    chk_probe_drive: assert property (@(posedge CLK) disable iff (!RESET_N)
        !decoded |-> STRAP_PULL_OE)
        else $error("strap not driven while probing");
    chk_pull_up: assert property (@(posedge CLK) disable iff (!RESET_N)
        (state_q == S_PULL_UP) |-> STRAP_PULL_OUT)
        else $error("strap not pulled up");
    chk_pull_down: assert property (@(posedge CLK) disable iff (!RESET_N)
        (state_q == S_PULL_DN) |-> !STRAP_PULL_OUT)
        else $error("strap not pulled down");
    chk_probe_release: assert property (@(posedge CLK) disable iff (!RESET_N)
        decoded |-> !STRAP_PULL_OE)
        else $error("strap still driven after decode");
    chk_decode_once: assert property (@(posedge CLK) disable iff (!RESET_N)
        (state_q == S_SAMPLE_DN) |=> decoded)
        else $error("decode did not finish");
    chk_cfg_empty: assert property (@(posedge CLK) disable iff (!RESET_N)
        !decoded |-> (cfg_q == '0))
        else $error("config set before decode");

    // lock behaviour
    chk_lock_set: assert property (@(posedge CLK) disable iff (!RESET_N)
        decoded |-> cfg_q.locked)
        else $error("lock missing after decode");
    chk_open_before: assert property (@(posedge CLK) disable iff (!RESET_N)
        !decoded |-> CFG_WR_ALLOW)
        else $error("write blocked before decode");
    chk_block_status: assert property (@(posedge CLK) disable iff (!RESET_N)
        wr_blocked |=> status_q[`HTM_ST_WR_BLOCK])
        else $error("blocked write not recorded");

    // queue and flag behaviour
    chk_idle_hold: assert property (@(posedge CLK) disable iff (!RESET_N)
        !meas_ok |=> ($stable(count_q) && $stable(trip_q)))
        else $error("queue moved without a reading");
    chk_count_bound: assert property (@(posedge CLK) disable iff (!RESET_N)
        count_q <= 8'(FAULT_QUEUE))
        else $error("queue count past its depth");
    chk_count_grows: assert property (@(posedge CLK) disable iff (!RESET_N)
        (meas_ok && over && count_q < 8'(FAULT_QUEUE)) |=> count_q == $past(count_q) + 8'h01)
        else $error("queue count did not advance");
    chk_trip_status: assert property (@(posedge CLK) disable iff (!RESET_N)
        trip_level_input |=> (trip_q && status_q[`HTM_ST_TRIP_LEVEL_INPUT]))
        else $error("trip_level_input not flagged");
    chk_clear_status: assert property (@(posedge CLK) disable iff (!RESET_N)
        trip_clr |=> status_q[`HTM_ST_TRIP_CLR])
        else $error("trip clear not recorded");
    chk_trip_held: assert property (@(posedge CLK) disable iff (!RESET_N)
        (trip_q && !(meas_ok && under)) |=> trip_q)
        else $error("trip dropped without a low reading");
    chk_status_sticky: assert property (@(posedge CLK) disable iff (!RESET_N)
        (status_q[`HTM_ST_TRIP_LEVEL_INPUT] && !clr_bits[`HTM_ST_TRIP_LEVEL_INPUT]) |=> status_q[`HTM_ST_TRIP_LEVEL_INPUT])
        else $error("trip status lost without a clear");
    chk_thresh_clamp: assert property (@(posedge CLK) disable iff (!RESET_N)
        (TRIP_LEVEL_INPUT >= (`HTM_TRIP_MAX_C - `HTM_TRIP_MIN_C)) |=> (thresh_q == `HTM_TRIP_MAX_C))
        else $error("threshold not clamped at top");
endmodule : htm_monitor

// ### rtl/htm_cfg.svh
/*
 * constants of the hard trip monitor: strap settling, threshold range, queue depth.
 * assumes it is included by bare name from the package.
 */
`ifndef HTM_CFG_SVH
`define HTM_CFG_SVH

// ****************************************
// threshold range in whole degrees
// ****************************************
`define HTM_TRIP_MIN_C 8'd60
`define HTM_TRIP_MAX_C 8'd122

// ****************************************
// fault queue and strap settling
// ****************************************
`define HTM_FAULT_QUEUE_DEF 4
`define HTM_STRAP_SETTLE_NS 1000
`define HTM_CLK_PERIOD_NS 25
`define HTM_STRAP_SETTLE_CYC ((`HTM_STRAP_SETTLE_NS + `HTM_CLK_PERIOD_NS - 1) / `HTM_CLK_PERIOD_NS)

// ****************************************
// status / interrupt register offsets and bits
// ****************************************
`define HTM_ADDR_STATUS 4'h0
`define HTM_ADDR_CLEAR 4'h1
`define HTM_ADDR_ENABLE 4'h2
`define HTM_ADDR_CONFIG 4'h3
`define HTM_ADDR_THRESH 4'h4
`define HTM_ST_TRIP_LEVEL_INPUT 0
`define HTM_ST_TRIP_CLR 1
`define HTM_ST_WR_BLOCK 2
`define HTM_ST_WIDTH 3

`endif

// ### rtl/htm_pkg.sv
/*
 * types of the hard trip monitor.
 * assumes htm_cfg.svh is on the include path.
 */
package htm_pkg;
    `include "htm_cfg.svh"

    // ****************************************
    // strap decode
    // ****************************************
    typedef enum logic [1:0] {HTM_STRAP_LOW, HTM_STRAP_OPEN, HTM_STRAP_HIGH} htm_strap_t;

    // channel configuration driven to the diode front end
    typedef struct packed {
        logic [1:0] channel;
        logic transistor_model;
        logic auto_detect;
        logic series_resistance_correction;
        logic locked;
    } htm_chan_cfg_t;

    // one temperature measurement
    typedef struct packed {
        logic valid;
        logic [1:0] channel;
        logic [7:0] degrees;
    } htm_meas_t;
endpackage : htm_pkg

// ### verification/htm_strap_model.sv
/*
 * strap pin model: tied low, tied high or left open on the board.
 * assumes the monitor probes the pin with a weak pull while its enable is high.
 */
`timescale 1ns/1ps

module htm_strap_model (
    // board strap choice: 0 low, 1 open, 2 high
    input wire logic [1:0] mode,
    // weak pull from the monitor
    input wire logic pull_out,
    input wire logic pull_oe,
    // pin level seen by the monitor
    output logic pin
);
    // ****************************************
    // pin level
    // ****************************************
    logic last_q = 1'b0;

    // an open pin with no pull has no defined level: show the inverse of the last one
    always @(mode or pull_out or pull_oe) begin
        case (mode)
            2'd0: pin = 1'b0;
            2'd2: pin = 1'b1;
            default: pin = pull_oe ? pull_out : ~last_q;
        endcase
        last_q = pin;
    end
endmodule : htm_strap_model

// ### verification/htm_monitor_tb_top.sv
/*
 * testbench of the hard trip monitor: strap modes, lock, trip queue, registers.
 * assumes the monitor and its package are compiled first.
 */
`timescale 1ns/1ps

`define CHK(what, exp, got) begin compares++; if ((got) !== (exp)) begin fails++; \
    $display("unexpected %s: expected %0h seen %0h", what, exp, got); end end

module htm_monitor_tb_top;
    import htm_pkg::*;
    logic clk = 1'b0, reset_n = 1'b0, strap_pin, pull_out, pull_oe, cfg_wr = 1'b0;
    logic [1:0] strap_mode = 2'd0, cfg_wr_chan = 2'd0;
    logic [7:0] trip_level = 8'd20, reg_wdata = 8'h00, rd;
    logic [3:0] reg_addr = 4'h0;
    logic reg_wr = 1'b0, reg_rd = 1'b0, cfg_wr_allow, trip_flag, irq;
    htm_meas_t meas = '0;
    htm_chan_cfg_t chan_cfg;
    int fails = 0, compares = 0;

    // ****************************************
    // clock, design and strap
    // ****************************************
    initial forever #12.5 clk = ~clk;
    htm_monitor htm_monitor_inst (.CLK(clk), .RESET_N(reset_n), .STRAP_IN(strap_pin),
        .STRAP_PULL_OUT(pull_out), .STRAP_PULL_OE(pull_oe), .TRIP_LEVEL_INPUT(trip_level),
        .MEAS(meas), .CFG_WR(cfg_wr), .CFG_WR_CHAN(cfg_wr_chan), .CFG_WR_ALLOW(cfg_wr_allow),
        .CHAN_CFG(chan_cfg), .HARD_TRIP_FLAG(trip_flag), .REG_ADDR(reg_addr),
        .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(rd), .IRQ(irq));
    htm_strap_model htm_strap_model_inst (.mode(strap_mode), .pull_out(pull_out),
        .pull_oe(pull_oe), .pin(strap_pin));

    // ****************************************
    // bus and stimulus tasks
    // ****************************************
    task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk) begin reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d; end
        @(posedge clk) reg_wr <= 1'b0;
    endtask : reg_write
    // read data stand only in the cycle after the strobe
    task automatic reg_read(input logic [3:0] a);
        @(posedge clk) begin reg_rd <= 1'b1; reg_addr <= a; end
        @(posedge clk) reg_rd <= 1'b0;
        #1;
    endtask : reg_read
    task automatic send_meas(input logic [1:0] ch, input logic [7:0] deg);
        @(posedge clk) meas <= '{valid: 1'b1, channel: ch, degrees: deg};
        @(posedge clk) meas.valid <= 1'b0;
        @(posedge clk) #1;
    endtask : send_meas
    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", compares, fails);
        if (fails == 0 && compares > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : complete_run
    // reset with a board strap, then wait for the probe to finish
    task automatic power_up(input logic [1:0] m);
        @(posedge clk) begin reset_n <= 1'b0; strap_mode <= m; end
        repeat (9) @(posedge clk);
        #1 `CHK("probe pull", 2'b11, {pull_oe, pull_out})
        @(posedge clk) reset_n <= 1'b1;
        for (int i = 0; i < 400 && pull_oe !== 1'b0; i++) @(posedge clk);
        if (pull_oe !== 1'b0) begin fails++; complete_run(); end
        @(posedge clk) #1;
    endtask : power_up

    // ****************************************
    // scenarios
    // ****************************************
    task automatic check_strap(input logic [1:0] m, ch, input logic tm, rc, ad, ad_chk);
        htm_chan_cfg_t held;
        power_up(m);
        `CHK("channel", ch, chan_cfg.channel)
        `CHK("model", tm, chan_cfg.transistor_model)
        `CHK("resistance", rc, chan_cfg.series_resistance_correction)
        `CHK("locked", 1'b1, chan_cfg.locked)
        if (ad_chk) `CHK("autodetect", ad, chan_cfg.auto_detect)
        for (int c = 0; c < 3; c++) begin
            @(posedge clk) begin cfg_wr <= 1'b1; cfg_wr_chan <= c[1:0]; end
            #1 `CHK("write allow", (c[1:0] != ch), cfg_wr_allow)
        end
        @(posedge clk) cfg_wr <= 1'b0;
        reg_read(4'h0);
        `CHK("blocked status", 8'h04, rd)
        reg_read(4'h3);
        `CHK("config reg", {2'b00, ch, tm, ad, rc, 1'b1}, rd)
        reg_write(4'h1, 8'h07);
        // board strap moved after power-up must not change anything
        held = chan_cfg;
        strap_mode <= m + 2'd1;
        repeat (100) @(posedge clk);
        `CHK("held cfg", held, chan_cfg)
    endtask : check_strap

    task automatic check_trip;
        for (int i = 0; i < 3; i++) send_meas(2'd1, 8'd85);
        send_meas(2'd1, 8'd80);
        for (int i = 0; i < 3; i++) send_meas(2'd1, 8'd90);
        `CHK("trip early", 1'b0, trip_flag)
        send_meas(2'd2, 8'd95);
        `CHK("other chan", 1'b0, trip_flag)
        send_meas(2'd1, 8'd81);
        `CHK("trip_level_input", 1'b1, trip_flag)
        send_meas(2'd1, 8'd80);
        `CHK("trip held", 1'b1, trip_flag)
        send_meas(2'd1, 8'd79);
        `CHK("trip clear", 1'b0, trip_flag)
        `CHK("irq masked", 1'b0, irq)
        reg_write(4'h2, 8'h01);
        reg_read(4'h2);
        `CHK("enable", 8'h01, rd)
        reg_read(4'h0);
        `CHK("status", 8'h03, rd)
        `CHK("irq", 1'b1, irq)
        reg_write(4'h1, 8'h03);
        #1 `CHK("irq cleared", 1'b0, irq)
        reg_read(4'h1);
        `CHK("clear reads", 8'h00, rd)
        reg_read(4'hf);
        `CHK("unmapped", 8'h00, rd)
    endtask : check_trip

    // threshold is sixty plus the code, clamped at the top of the range
    task automatic check_threshold;
        logic [7:0] codes[3] = '{8'd0, 8'd62, 8'd200};
        logic [7:0] exp[3] = '{8'd60, 8'd122, 8'd122};
        for (int i = 0; i < 3; i++) begin
            @(posedge clk) trip_level <= codes[i];
            repeat (3) @(posedge clk);
            reg_read(4'h4);
            `CHK("threshold", exp[i], rd)
        end
        @(posedge clk) trip_level <= 8'd20;
    endtask : check_threshold

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        check_strap(2'd0, 2'd1, 1'b1, 1'b1, 1'b0, 1'b1);
        check_threshold();
        repeat (3) @(posedge clk);
        check_trip();
        check_strap(2'd1, 2'd1, 1'b0, 1'b0, 1'b0, 1'b1);
        check_strap(2'd2, 2'd2, 1'b1, 1'b1, 1'b1, 1'b1);
        complete_run();
    end
endmodule : htm_monitor_tb_top
